// [rtl/dmsd_consts.vh]
// Purpose: shared constants of the data memory space decoder
// Assumes: included by bare name from the design files
// Notes: offsets, field positions, reset values and encodings only
`ifndef DMSD_CONSTS_VH
`define DMSD_CONSTS_VH

// register port offsets (4-bit address)
`define DMSD_OFS_PSW 4'h0
`define DMSD_OFS_AUX 4'h1
`define DMSD_OFS_STAT 4'h2

// program_status_word field positions
`define DMSD_PSW_BANK_HI 4
`define DMSD_PSW_BANK_LO 3
`define DMSD_PSW_RST 8'h00

// auxiliary_control_register field positions
`define DMSD_AUX_OFFCHIP 1
`define DMSD_AUX_SIZE_HI 3
`define DMSD_AUX_SIZE_LO 2
// reset: on-chip expanded ram selected, full 2K size
`define DMSD_AUX_RST 8'h0C
`define DMSD_AUX_MASK 8'h0E

// access modes from the core
`define DMSD_MODE_DIRECT 3'h0
`define DMSD_MODE_INDIRECT 3'h1
`define DMSD_MODE_REG 3'h2
`define DMSD_MODE_BIT 3'h3
`define DMSD_MODE_XMOVE 3'h4

// address map figures
`define DMSD_UPPER_BIT 7
`define DMSD_BITAREA_BASE 8'h20
`define DMSD_EXPANDED_INTERNAL_MEMORY_END_256 16'h00FF
`define DMSD_EXPANDED_INTERNAL_MEMORY_END_512 16'h01FF
`define DMSD_EXPANDED_INTERNAL_MEMORY_END_1K 16'h03FF
`define DMSD_EXPANDED_INTERNAL_MEMORY_END_2K 16'h07FF

// one-hot segment codes, also seen in the status register
`define DMSD_SEG_NONE 5'h00
`define DMSD_SEG_LOWER 5'h01
`define DMSD_SEG_UPPER 5'h02
`define DMSD_SEG_SFR 5'h04
`define DMSD_SEG_EXPANDED_INTERNAL_MEMORY 5'h08
`define DMSD_SEG_EXT 5'h10

`endif

// [rtl/dmsd_decoder.v]
// Purpose: decode core data accesses into lower/upper ram, sfr, expanded ram, external
// Assumes: one core request per cycle at most; register port strobes one cycle long
// Notes: sfr and external accesses are only forwarded; their answers come elsewhere
//
// What this block does
// [RULE_01] lower ram at 00h-7Fh, direct and indirect
// [RULE_02] lowest 32 bytes form four register banks
// [RULE_03] bank bits pick 00h, 08h, 10h, 18h base
// [RULE_04] 16 bytes above banks are bit addressable
// [RULE_05] upper ram 80h-FFh reached only indirectly
// [RULE_06] direct 80h-FFh goes to function registers
// [RULE_07] 2K expanded ram via indirect external moves
// [RULE_08] offchip select routes moves on or off chip
// [RULE_09] size field sets expanded ram end address
// [RULE_10] moves above selected size go off chip
// [RULE_11] ram contents undefined; software initialises them
// [RULE_12] bank bits sit at status word bits 4:3
// [RULE_13] on-chip expanded accesses leave external pins idle
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "dmsd_consts.vh"
module dmsd_decoder #(
  parameter IDATA_AW = 8,
  parameter EXPANDED_INTERNAL_MEMORY_AW = 11
) (
  input wire MCLK_IN,
  input wire RST_N_IN,
  // core access port
  input wire ACC_REQ_IN,
  input wire ACC_WR_IN,
  input wire [2:0] ACC_MODE_IN,
  input wire [15:0] ACC_ADDR_IN,
  input wire [7:0] ACC_WDATA_IN,
  output wire [7:0] ACC_RDATA_OUT,
  output reg ACC_DONE_OUT,
  // forwarded special function register access
  output reg SFR_REQ_OUT,
  output reg SFR_WR_OUT,
  output reg [7:0] SFR_ADDR_OUT,
  output reg [7:0] SFR_MASK_OUT,
  output reg [7:0] SFR_WDATA_OUT,
  // forwarded external data memory access
  output reg EXT_REQ_OUT,
  output reg EXT_WR_OUT,
  output reg [15:0] EXT_ADDR_OUT,
  output reg [7:0] EXT_WDATA_OUT,
  // register port
  input wire [3:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  output reg [7:0] REG_RDATA_OUT
);
  // software-visible control
  reg [7:0] program_status_word_q; // bank select lives in bits 4:3
  reg [7:0] aux_ctrl_q; // offchip select and size field
  reg [4:0] last_seg_q; // segment of the latest access
  reg [4:0] last_seg_d;

  // decoded fields of the control registers
  wire [1:0] bank_sel;
  wire offchip_ram_select;
  wire [1:0] expanded_ram_size_select;

  // per-access decode results
  reg [4:0] seg_d; // one-hot target segment
  reg [7:0] idata_addr_d; // byte address into the 256-byte internal ram
  reg [7:0] mask_d; // bit lanes touched
  reg [15:0] expanded_internal_memory_end; // last on-chip expanded address
  reg [7:0] sfr_addr_d;

  // delayed view of the answered access
  reg [4:0] seg_q;
  reg bit_rd_q;
  reg [2:0] bit_pos_q;

  // memory side signals
  wire idata_en;
  wire expanded_internal_memory_en;
  wire [7:0] idata_q;
  wire [7:0] expanded_internal_memory_q;
  wire [7:0] byte_q;
  wire [7:0] wdata_bits;

  // [RULE_12] bank field position
  assign bank_sel = program_status_word_q[`DMSD_PSW_BANK_HI:`DMSD_PSW_BANK_LO];
  assign offchip_ram_select = aux_ctrl_q[`DMSD_AUX_OFFCHIP];
  assign expanded_ram_size_select = aux_ctrl_q[`DMSD_AUX_SIZE_HI:`DMSD_AUX_SIZE_LO];

  // [RULE_09] size field to end address
  always @*
  begin
    case (expanded_ram_size_select)
      2'b00: expanded_internal_memory_end = `DMSD_EXPANDED_INTERNAL_MEMORY_END_256;
      2'b01: expanded_internal_memory_end = `DMSD_EXPANDED_INTERNAL_MEMORY_END_512;
      2'b10: expanded_internal_memory_end = `DMSD_EXPANDED_INTERNAL_MEMORY_END_1K;
      2'b11: expanded_internal_memory_end = `DMSD_EXPANDED_INTERNAL_MEMORY_END_2K;
      default: expanded_internal_memory_end = `DMSD_EXPANDED_INTERNAL_MEMORY_END_2K;
    endcase
  end

  // address decode by mode; the mode, not the address, separates upper ram from sfr
  always @*
  begin
    seg_d = `DMSD_SEG_NONE;
    idata_addr_d = ACC_ADDR_IN[7:0];
    mask_d = 8'hFF;
    sfr_addr_d = ACC_ADDR_IN[7:0];
    case (ACC_MODE_IN)
      `DMSD_MODE_DIRECT:
      begin
        // [RULE_06] direct high half to sfr
        if (ACC_ADDR_IN[`DMSD_UPPER_BIT])
          seg_d = `DMSD_SEG_SFR;
        // [RULE_01] direct lower ram
        else
          seg_d = `DMSD_SEG_LOWER;
      end
      `DMSD_MODE_INDIRECT:
      begin
        // [RULE_05] indirect reaches upper ram
        if (ACC_ADDR_IN[`DMSD_UPPER_BIT])
          seg_d = `DMSD_SEG_UPPER;
        // [RULE_01] indirect lower ram
        else
          seg_d = `DMSD_SEG_LOWER;
      end
      `DMSD_MODE_REG:
      begin
        // [RULE_02] register in active bank
        // [RULE_03] bank base from select bits
        seg_d = `DMSD_SEG_LOWER;
        idata_addr_d = {3'b000, bank_sel, ACC_ADDR_IN[2:0]};
      end
      `DMSD_MODE_BIT:
      begin
        // one lane only, chosen by the low three bits
        mask_d = 8'h01 << ACC_ADDR_IN[2:0];
        if (ACC_ADDR_IN[`DMSD_UPPER_BIT])
        begin
          // high bit addresses land in bit-addressable sfr bytes
          seg_d = `DMSD_SEG_SFR;
          sfr_addr_d = {ACC_ADDR_IN[7:3], 3'b000};
        end
        else
        begin
          // [RULE_04] bit area above banks
          seg_d = `DMSD_SEG_LOWER;
          idata_addr_d = `DMSD_BITAREA_BASE | {4'h0, ACC_ADDR_IN[6:3]};
        end
      end
      `DMSD_MODE_XMOVE:
      begin
        // [RULE_07] external move into expanded ram
        // [RULE_08] offchip select steering
        // [RULE_10] beyond size goes off chip
        if (!offchip_ram_select && (ACC_ADDR_IN <= expanded_internal_memory_end))
          seg_d = `DMSD_SEG_EXPANDED_INTERNAL_MEMORY;
        else
          seg_d = `DMSD_SEG_EXT;
      end
      default:
      begin
        // unknown mode: nothing is touched
        seg_d = `DMSD_SEG_NONE;
      end
    endcase
  end

  // enables for the two internal memories
  assign idata_en = ACC_REQ_IN &&
    ((seg_d == `DMSD_SEG_LOWER) || (seg_d == `DMSD_SEG_UPPER));
  assign expanded_internal_memory_en = ACC_REQ_IN && (seg_d == `DMSD_SEG_EXPANDED_INTERNAL_MEMORY);
  // a bit store carries its value in bit 0; replicate it onto every lane
  assign wdata_bits = (ACC_MODE_IN == `DMSD_MODE_BIT) ? {8{ACC_WDATA_IN[0]}} : ACC_WDATA_IN;

  // [RULE_11] internal ram left uninitialised
  dmsd_ram #(
    .AW(IDATA_AW),
    .DW(8)
  ) u_idata (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .en_in(idata_en),
    .we_in(ACC_WR_IN),
    .addr_in(idata_addr_d[IDATA_AW-1:0]),
    .mask_in(mask_d),
    .wdata_in(wdata_bits),
    .rdata_out(idata_q)
  );

  // expanded ram, also uninitialised
  dmsd_ram #(
    .AW(EXPANDED_INTERNAL_MEMORY_AW),
    .DW(8)
  ) u_expanded_internal_memory (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .en_in(expanded_internal_memory_en),
    .we_in(ACC_WR_IN),
    .addr_in(ACC_ADDR_IN[EXPANDED_INTERNAL_MEMORY_AW-1:0]),
    .mask_in(8'hFF),
    .wdata_in(ACC_WDATA_IN),
    .rdata_out(expanded_internal_memory_q)
  );

  // answer tracking: which memory answers in the next cycle
  always @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      seg_q <= `DMSD_SEG_NONE;
      bit_rd_q <= 1'b0;
      bit_pos_q <= 3'h0;
      ACC_DONE_OUT <= 1'b0;
    end
    else
    begin
      seg_q <= ACC_REQ_IN ? seg_d : `DMSD_SEG_NONE;
      bit_rd_q <= ACC_REQ_IN && !ACC_WR_IN && (ACC_MODE_IN == `DMSD_MODE_BIT);
      bit_pos_q <= ACC_ADDR_IN[2:0];
      // internal segments finish here; forwarded ones are answered by their owners
      ACC_DONE_OUT <= idata_en || expanded_internal_memory_en;
    end
  end

  // read data: pick the answering memory, then extract a bit if asked
  assign byte_q = (seg_q == `DMSD_SEG_EXPANDED_INTERNAL_MEMORY) ? expanded_internal_memory_q :
    (((seg_q == `DMSD_SEG_LOWER) || (seg_q == `DMSD_SEG_UPPER)) ? idata_q : 8'h00);
  assign ACC_RDATA_OUT = bit_rd_q ? {7'h00, byte_q[bit_pos_q]} : byte_q;

  // forward sfr accesses as a one-cycle registered request
  always @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      SFR_REQ_OUT <= 1'b0;
      SFR_WR_OUT <= 1'b0;
      SFR_ADDR_OUT <= 8'h00;
      SFR_MASK_OUT <= 8'h00;
      SFR_WDATA_OUT <= 8'h00;
    end
    else
    begin
      SFR_REQ_OUT <= ACC_REQ_IN && (seg_d == `DMSD_SEG_SFR);
      if (ACC_REQ_IN && (seg_d == `DMSD_SEG_SFR))
      begin
        SFR_WR_OUT <= ACC_WR_IN;
        SFR_ADDR_OUT <= sfr_addr_d;
        SFR_MASK_OUT <= mask_d;
        SFR_WDATA_OUT <= wdata_bits;
      end
    end
  end

  // forward off-chip moves; on-chip ones never touch these outputs
  always @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      EXT_REQ_OUT <= 1'b0;
      EXT_WR_OUT <= 1'b0;
      EXT_ADDR_OUT <= 16'h0000;
      EXT_WDATA_OUT <= 8'h00;
    end
    else
    begin
      // [RULE_13] only off-chip moves drive out
      EXT_REQ_OUT <= ACC_REQ_IN && (seg_d == `DMSD_SEG_EXT);
      if (ACC_REQ_IN && (seg_d == `DMSD_SEG_EXT))
      begin
        EXT_WR_OUT <= ACC_WR_IN;
        EXT_ADDR_OUT <= ACC_ADDR_IN;
        EXT_WDATA_OUT <= ACC_WDATA_IN;
      end
    end
  end

  // status: remember the latest target segment
  always @*
  begin
    last_seg_d = last_seg_q;
    if (ACC_REQ_IN && (seg_d != `DMSD_SEG_NONE))
      last_seg_d = seg_d;
  end

  // control registers written from the register port
  always @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      program_status_word_q <= `DMSD_PSW_RST;
      aux_ctrl_q <= `DMSD_AUX_RST;
      last_seg_q <= `DMSD_SEG_NONE;
    end
    else
    begin
      last_seg_q <= last_seg_d;
      if (REG_WR_IN && (REG_ADDR_IN == `DMSD_OFS_PSW))
        program_status_word_q <= REG_WDATA_IN;
      // unused bits of the aux register stay zero
      if (REG_WR_IN && (REG_ADDR_IN == `DMSD_OFS_AUX))
        aux_ctrl_q <= REG_WDATA_IN & `DMSD_AUX_MASK;
    end
  end

  // read data stands in the cycle after the read strobe only
  always @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      REG_RDATA_OUT <= 8'h00;
    end
    else if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        `DMSD_OFS_PSW: REG_RDATA_OUT <= program_status_word_q;
        `DMSD_OFS_AUX: REG_RDATA_OUT <= aux_ctrl_q;
        `DMSD_OFS_STAT: REG_RDATA_OUT <= {3'b000, last_seg_q};
        // unmapped offsets read as zero
        default: REG_RDATA_OUT <= 8'h00;
      endcase
    end
    else
    begin
      REG_RDATA_OUT <= 8'h00;
    end
  end
endmodule // dmsd_decoder

// [rtl/dmsd_ram.v]
// Purpose: single-port byte memory with bit write mask and registered read
// Assumes: one access per cycle, synchronous to clk_in
// Notes: array is never cleared; contents are undefined after power-up
`timescale 1ns/1ps
module dmsd_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire en_in,
  input wire we_in,
  input wire [AW-1:0] addr_in,
  input wire [DW-1:0] mask_in,
  input wire [DW-1:0] wdata_in,
  output reg [DW-1:0] rdata_out
);
  // storage, deliberately without reset
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // masked write keeps unselected bits, so bit stores need no extra read cycle
  always @(posedge clk_in)
  begin
    if (en_in && we_in)
    begin
      mem[addr_in] <= (mem[addr_in] & ~mask_in) | (wdata_in & mask_in);
    end
  end

  // registered read port; reset only clears the output flop
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_out <= {DW{1'b0}};
    end
    else if (en_in && !we_in)
    begin
      rdata_out <= mem[addr_in];
    end
  end
endmodule // dmsd_ram

// [verification/dmsd_core_model.sv]
// Purpose: processor core issuing single data accesses
// Assumes: request held for exactly one edge, then dropped
// Notes: a gap cycle follows each access, so answers never overlap
`timescale 1ns/1ps
module dmsd_core_model (
  input wire logic clk_in,
  output logic req_out,
  output logic wr_out,
  output logic [2:0] mode_out,
  output logic [15:0] addr_out,
  output logic [7:0] wdata_out
);
  // idle request at time zero
  initial
  begin
    req_out = 1'h0;
    wr_out = 1'h0;
    mode_out = 3'h0;
    addr_out = 16'h0000;
    wdata_out = 8'h00;
  end
  // one access: launch after an edge, drop after the taking edge
  task automatic acc(input logic [2:0] m, input logic w, input logic [15:0] a,
    input logic [7:0] d);
    @(posedge clk_in);
    req_out <= 1'h1;
    wr_out <= w;
    mode_out <= m;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    req_out <= 1'h0;
  endtask
endmodule // dmsd_core_model

// [verification/dmsd_decoder_asserts.sv]
// Purpose: port-level checks of the data memory space decoder
// Assumes: one core request per cycle, answers one cycle later
// Notes: size field is not tracked, so only moves above 07FFh are pinned
`timescale 1ns/1ps
`include "dmsd_consts.vh"
module dmsd_decoder_chk (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic ACC_REQ_IN,
  input wire logic [2:0] ACC_MODE_IN,
  input wire logic [15:0] ACC_ADDR_IN,
  input wire logic ACC_DONE_OUT,
  input wire logic SFR_REQ_OUT,
  input wire logic [7:0] SFR_ADDR_OUT,
  input wire logic [7:0] SFR_MASK_OUT,
  input wire logic EXT_REQ_OUT,
  input wire logic [15:0] EXT_ADDR_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // request kinds and address pieces
  wire is_dir = ACC_REQ_IN && ACC_MODE_IN == `DMSD_MODE_DIRECT;
  wire is_ind = ACC_REQ_IN && ACC_MODE_IN == `DMSD_MODE_INDIRECT;
  wire is_reg = ACC_REQ_IN && ACC_MODE_IN == `DMSD_MODE_REG;
  wire is_bit = ACC_REQ_IN && ACC_MODE_IN == `DMSD_MODE_BIT;
  wire is_mov = ACC_REQ_IN && ACC_MODE_IN == `DMSD_MODE_XMOVE;
  wire [7:0] byte_of_bit = {ACC_ADDR_IN[7:3], 3'h0};
  wire [7:0] mask_of_bit = 8'h01 << ACC_ADDR_IN[2:0];
  low_direct_a: assert property (is_dir && !ACC_ADDR_IN[7] |=> ACC_DONE_OUT)
    else $error("direct low access not completed");
  sfr_direct_a: assert property (is_dir && ACC_ADDR_IN[7] |=> SFR_REQ_OUT
    && !ACC_DONE_OUT)
    else $error("direct high access not forwarded");
  upper_indirect_a: assert property (is_ind |=> ACC_DONE_OUT && !SFR_REQ_OUT)
    else $error("indirect access not internal");
  reg_bank_a: assert property (is_reg |=> ACC_DONE_OUT)
    else $error("working register access not completed");
  bit_low_a: assert property (is_bit && !ACC_ADDR_IN[7] |=> ACC_DONE_OUT)
    else $error("bit access not completed");
  bit_sfr_a: assert property (is_bit && ACC_ADDR_IN[7] |=> SFR_REQ_OUT
    && SFR_ADDR_OUT == $past(byte_of_bit) && SFR_MASK_OUT == $past(mask_of_bit))
    else $error("high bit access forwarded wrongly");
  move_above_a: assert property (is_mov && ACC_ADDR_IN > 16'h07FF |=> EXT_REQ_OUT
    && !ACC_DONE_OUT && EXT_ADDR_OUT == $past(ACC_ADDR_IN))
    else $error("move above expanded ram not external");
  move_route_a: assert property (is_mov |=> $onehot({ACC_DONE_OUT, EXT_REQ_OUT}))
    else $error("move not routed to exactly one place");
  onchip_quiet_a: assert property (ACC_DONE_OUT |-> !EXT_REQ_OUT && !SFR_REQ_OUT)
    else $error("internal access also drove a forward");
  bad_mode_a: assert property (ACC_REQ_IN && ACC_MODE_IN > 3'h4 |=>
    !(ACC_DONE_OUT || SFR_REQ_OUT || EXT_REQ_OUT))
    else $error("illegal mode produced an answer");
  // main scenarios reached
  cover property (is_reg ##1 ACC_DONE_OUT);
  cover property (is_bit && ACC_ADDR_IN[7]);
  cover property (is_mov ##1 EXT_REQ_OUT);
endmodule // dmsd_decoder_chk
bind dmsd_decoder dmsd_decoder_chk u_chk (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
  .ACC_REQ_IN(ACC_REQ_IN), .ACC_MODE_IN(ACC_MODE_IN), .ACC_ADDR_IN(ACC_ADDR_IN),
  .ACC_DONE_OUT(ACC_DONE_OUT), .SFR_REQ_OUT(SFR_REQ_OUT), .SFR_ADDR_OUT(SFR_ADDR_OUT),
  .SFR_MASK_OUT(SFR_MASK_OUT), .EXT_REQ_OUT(EXT_REQ_OUT), .EXT_ADDR_OUT(EXT_ADDR_OUT));

// [verification/testbench.sv]
// Purpose: scenario tests of the data memory space decoder
// Assumes: core model drives the access port, bench the register port
// Notes: every ram location is written before it is read
`timescale 1ns/1ps
`include "dmsd_consts.vh"
module testbench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic req, wr, done, sfr_req, ext_req, sfr_wr, ext_wr, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [2:0] mode;
  logic [15:0] addr, ext_addr, e;
  logic [7:0] wdata, rdata, sfr_addr, sfr_mask, sfr_wdata, ext_wdata, d;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [3:0] reg_addr = 4'h0;
  int fail_count = 0, check_count = 0, cyc = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  dmsd_core_model core (.clk_in(clk), .req_out(req), .wr_out(wr), .mode_out(mode),
    .addr_out(addr), .wdata_out(wdata));
  dmsd_decoder uut (.MCLK_IN(clk), .RST_N_IN(rst_n), .ACC_REQ_IN(req), .ACC_WR_IN(wr),
    .ACC_MODE_IN(mode), .ACC_ADDR_IN(addr), .ACC_WDATA_IN(wdata), .ACC_RDATA_OUT(rdata),
    .ACC_DONE_OUT(done), .SFR_REQ_OUT(sfr_req), .SFR_WR_OUT(sfr_wr), .SFR_ADDR_OUT(sfr_addr),
    .SFR_MASK_OUT(sfr_mask), .SFR_WDATA_OUT(sfr_wdata), .EXT_REQ_OUT(ext_req),
    .EXT_WR_OUT(ext_wr), .EXT_ADDR_OUT(ext_addr), .EXT_WDATA_OUT(ext_wdata),
    .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
    .REG_RDATA_OUT(reg_rdata));
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, far above the roughly 120 cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // register port write and read, one-cycle strobes
  task automatic rwr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rrd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask
  // core access, answer sampled in the following cycle
  task automatic acc(input logic [2:0] m, input logic w, input logic [15:0] a,
    input logic [7:0] v);
    core.acc(m, w, a, v);
    #1;
  endtask
  task automatic t_regs();
    rrd(`DMSD_OFS_PSW, d);
    chk("psw reset", 16'(`DMSD_PSW_RST), 16'(d));
    rrd(`DMSD_OFS_AUX, d);
    chk("aux reset", 16'(`DMSD_AUX_RST), 16'(d));
    rwr(`DMSD_OFS_AUX, 8'hFF);
    rrd(`DMSD_OFS_AUX, d);
    chk("aux mask", 16'(`DMSD_AUX_MASK), 16'(d));
    rrd(4'hF, d);
    chk("unmapped", 16'h0000, 16'(d));
    acc(3'h6, 1'h1, 16'h0010, 8'h00);
    chk("bad mode", 16'h0000, 16'({done, sfr_req, ext_req}));
  endtask
  // each bank value lands at bank base plus three
  task automatic t_banks();
    for (int b = 0; b < 4; b++)
    begin
      rwr(`DMSD_OFS_PSW, 8'(b << `DMSD_PSW_BANK_LO));
      acc(`DMSD_MODE_REG, 1'h1, 16'h0003, 8'(8'hA0 + b));
      chk("reg done", 16'h0001, 16'(done));
      acc(`DMSD_MODE_INDIRECT, 1'h0, 16'(b * 8 + 3), 8'h00);
      chk("bank byte", 16'(8'hA0 + b), 16'(rdata));
    end
  endtask
  task automatic t_spaces();
    acc(`DMSD_MODE_DIRECT, 1'h1, 16'h007F, 8'h5A);
    acc(`DMSD_MODE_INDIRECT, 1'h0, 16'h007F, 8'h00);
    chk("lower 7F", 16'h005A, 16'(rdata));
    acc(`DMSD_MODE_INDIRECT, 1'h1, 16'h0080, 8'hC3);
    acc(`DMSD_MODE_DIRECT, 1'h1, 16'h0080, 8'h11);
    chk("sfr fwd", 16'h0180, 16'({sfr_req, sfr_addr}));
    chk("sfr data", 16'h0111, 16'({sfr_wr, sfr_wdata}));
    acc(`DMSD_MODE_INDIRECT, 1'h0, 16'h0080, 8'h00);
    chk("upper 80", 16'h00C3, 16'(rdata));
  endtask
  task automatic t_bits();
    // byte cleared first, contents are undefined until written
    acc(`DMSD_MODE_INDIRECT, 1'h1, 16'h0021, 8'h00);
    acc(`DMSD_MODE_BIT, 1'h1, 16'h000A, 8'h01);
    acc(`DMSD_MODE_INDIRECT, 1'h0, 16'h0021, 8'h00);
    chk("bit byte", 16'h0004, 16'(rdata));
    acc(`DMSD_MODE_BIT, 1'h0, 16'h000A, 8'h00);
    chk("bit read", 16'h0001, 16'(rdata));
    // high bit address goes out as byte 88h, lane 5, value on every lane
    acc(`DMSD_MODE_BIT, 1'h1, 16'h008D, 8'h01);
    chk("bit sfr", 16'h0188, 16'({sfr_req, sfr_addr}));
    chk("bit lane", 16'h0020, 16'(sfr_mask));
    chk("bit value", 16'h01FF, 16'({sfr_wr, sfr_wdata}));
  endtask
  // every size: last internal byte, first external byte, then off chip
  task automatic t_expanded_internal_memory();
    for (int s = 0; s < 4; s++)
    begin
      e = 16'((16'h0100 << s) - 1);
      rwr(`DMSD_OFS_AUX, 8'(s << `DMSD_AUX_SIZE_LO));
      acc(`DMSD_MODE_XMOVE, 1'h1, e, 8'(s + 1));
      acc(`DMSD_MODE_XMOVE, 1'h0, e, 8'h00);
      chk("expanded_internal_memory end", 16'(s + 1), 16'({ext_req, rdata}));
      acc(`DMSD_MODE_XMOVE, 1'h0, e + 16'h0001, 8'h00);
      chk("above size", e + 16'h0001, ext_addr);
      chk("above req", 16'h0001, 16'({done, ext_req}));
      chk("above rd", 16'h0000, 16'(ext_wr));
      // an on-chip write must leave the forwarded address alone
      acc(`DMSD_MODE_XMOVE, 1'h1, 16'h0000, 8'h3C);
      chk("onchip quiet", e + 16'h0001, ext_addr);
    end
    rwr(`DMSD_OFS_AUX, 8'h0E);
    acc(`DMSD_MODE_XMOVE, 1'h1, 16'h0000, 8'h77);
    chk("offchip", 16'h0001, 16'({done, ext_req}));
    chk("offchip data", 16'h0177, 16'({ext_wr, ext_wdata}));
    rrd(`DMSD_OFS_STAT, d);
    chk("status", 16'(`DMSD_SEG_EXT), 16'(d));
  endtask
  // mid-run reset: control registers and status back to their reset values
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk("reset quiet", 16'h0000, 16'({done, sfr_req, ext_req, reg_rdata}));
    @(posedge clk);
    rst_n <= 1'h1;
    rrd(`DMSD_OFS_PSW, d);
    chk("psw again", 16'(`DMSD_PSW_RST), 16'(d));
    rrd(`DMSD_OFS_AUX, d);
    chk("aux again", 16'(`DMSD_AUX_RST), 16'(d));
    rrd(`DMSD_OFS_STAT, d);
    chk("status again", 16'h0000, 16'(d));
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_banks();
    t_spaces();
    t_bits();
    t_expanded_internal_memory();
    t_reset();
    end_sim();
  end
endmodule // testbench
